// ### timed_unlock_pkg.sv
// constants for the timed write unlock gate
package timed_unlock_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_UNLOCK_KEY    = 8'hC7;
  localparam logic [7:0] IDX_WATCHDOG_CTRL = 8'hD8;
  localparam logic [7:0] IDX_EXT_FLAG      = 8'h40;
  localparam logic [7:0] IDX_UNLOCK_STATUS = 8'h41;

  // ----------------------------------------------------------------
  // key bytes
  // ----------------------------------------------------------------
  localparam logic [7:0] KEY_FIRST  = 8'hAA;
  localparam logic [7:0] KEY_SECOND = 8'h55;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int POS_WD_RESTART = 0;
  localparam int POS_WD_ENABLE  = 1;
  localparam int POS_WD_IRQ     = 3;
  localparam int POS_POR_FLAG   = 6;
  localparam int POS_BANDGAP    = 0;
  localparam int POS_ST_OPEN    = 0;
  localparam int POS_ST_ARMED   = 1;

  localparam logic [7:0] WATCHDOG_CONTROL_REG_PROT_MASK = 8'h4B;
  localparam logic [7:0] EXTENDED_FLAG_REG_PROT_MASK  = 8'h01;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] WATCHDOG_CONTROL_REG_RESET = 8'h00;
  localparam logic [7:0] EXTENDED_FLAG_REG_RESET  = 8'h00;

  // ----------------------------------------------------------------
  // timing: window length in instruction cycles, clocks per cycle
  // ----------------------------------------------------------------
  localparam int WINDOW_INSTR_CYCLES = 3;
  localparam int CLOCKS_PER_INSTR    = 4;
  localparam int WINDOW_CLOCKS = WINDOW_INSTR_CYCLES * CLOCKS_PER_INSTR;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SEQ_IDLE  = 3'b001,
    SEQ_ARMED = 3'b010,
    SEQ_OPEN  = 3'b100
  } seq_state_e;

endpackage

// ### timed_write_unlock.sv
// timed write unlock gate with avalon-mm register slave
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
// Operation
// R1: key AAh then 55h to key register
// R2: correct key opens three instruction cycle window
// R3: protected write outside window is discarded
// R4: watchdog irq, enable, restart need window
// R5: bandgap select and power-on flag need window
// R6: wrong byte after AAh abandons the sequence; a repeated AAh keeps it armed
module timed_write_unlock #(
  parameter int ADDR_W = 12,
  parameter int CNT_W  = 8
) (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              resetn,
  // avalon-mm slave
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [3:0]        avs_byteenable,
  input  wire logic [31:0]       avs_writedata,
  output logic [31:0]            avs_readdata,
  output logic                   avs_waitrequest,
  // hardware flag sets
  input  wire logic              wdt_irq_set,
  input  wire logic              por_set,
  // protected controls
  output logic [7:0]             watchdog_control_reg,
  output logic [7:0]             extended_flag_reg,
  output logic                   bandgap_select,
  output logic                   watchdog_enable_bit,
  output logic                   watchdog_restart_bit,
  output logic                   watchdog_irq_flag,
  output logic                   por_flag,
  output logic                   unlock_open
);

  initial begin
    if (ADDR_W < 11)
      $error("timed_write_unlock: ADDR_W must be at least 11");
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr,
                                   input logic [7:0]        idx);
    logic [ADDR_W-1:0] want;
    want = {{(ADDR_W-10){1'b0}}, idx, 2'b00};
    return addr == want;
  endfunction

  function automatic logic [7:0] merge(input logic [7:0] old,
                                       input logic [7:0] wd,
                                       input logic [7:0] ok);
    return (old & ~ok) | (wd & ok);
  endfunction

  // ----------------------------------------------------------------
  // bus handshake: one wait cycle, then accept
  // ----------------------------------------------------------------
  logic        ack_q;
  logic        ack_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic        wr_take;
  logic        byte0_wr;

  always_comb begin
    ack_d = (avs_read || avs_write) && !ack_q;
  end

  assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
  assign wr_take         = avs_write && ack_q;
  assign byte0_wr        = wr_take && avs_byteenable[0];

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic hit_key;
  logic hit_watchdog_control_reg;
  logic hit_extended_flag_reg;
  logic hit_status;
  logic key_wr;
  logic watchdog_control_reg_wr;
  logic extended_flag_reg_wr;
  logic prot_wr;
  logic armed;
  logic window_open;

  assign hit_key    = reg_hit(avs_address, timed_unlock_pkg::IDX_UNLOCK_KEY);
  assign hit_watchdog_control_reg  = reg_hit(avs_address,
                              timed_unlock_pkg::IDX_WATCHDOG_CTRL);
  assign hit_extended_flag_reg   = reg_hit(avs_address, timed_unlock_pkg::IDX_EXT_FLAG);
  assign hit_status = reg_hit(avs_address,
                              timed_unlock_pkg::IDX_UNLOCK_STATUS);

  assign key_wr   = byte0_wr && hit_key; // [R1]
  assign watchdog_control_reg_wr = byte0_wr && hit_watchdog_control_reg;
  assign extended_flag_reg_wr  = byte0_wr && hit_extended_flag_reg;
  // a write to a register holding protected bits uses up the window
  assign prot_wr  = watchdog_control_reg_wr || extended_flag_reg_wr;

  // ----------------------------------------------------------------
  // key sequence and window
  // ----------------------------------------------------------------
  unlock_sequencer #(
    .WINDOW_LEN (timed_unlock_pkg::WINDOW_CLOCKS),
    .CNT_W      (CNT_W)
  ) u_seq (
    .mclk        (mclk),
    .resetn      (resetn),
    .key_wr      (key_wr),
    .key_data    (avs_writedata[7:0]),
    .prot_wr     (prot_wr),
    .armed       (armed),
    .window_open (window_open)
  );

  // ----------------------------------------------------------------
  // protected registers
  // ----------------------------------------------------------------
  logic [7:0] watchdog_control_reg_q;
  logic [7:0] watchdog_control_reg_d;
  logic [7:0] extended_flag_reg_q;
  logic [7:0] extended_flag_reg_d;
  logic [7:0] watchdog_control_reg_ok;
  logic [7:0] extended_flag_reg_ok;

  always_comb begin
    // protected bits writable only while the window is open
    watchdog_control_reg_ok = window_open ? 8'hFF
                           : ~timed_unlock_pkg::WATCHDOG_CONTROL_REG_PROT_MASK; // [R3] [R4]
    extended_flag_reg_ok  = window_open ? 8'hFF
                           : ~timed_unlock_pkg::EXTENDED_FLAG_REG_PROT_MASK; // [R3] [R5]
    watchdog_control_reg_d  = watchdog_control_reg_q;
    extended_flag_reg_d   = extended_flag_reg_q;
    // restart bit is a one-cycle request
    watchdog_control_reg_d[timed_unlock_pkg::POS_WD_RESTART] = 1'b0;
    if (watchdog_control_reg_wr) begin
      watchdog_control_reg_d = merge(watchdog_control_reg_q, avs_writedata[7:0], watchdog_control_reg_ok); // [R4] [R5]
      if (!window_open) begin
        watchdog_control_reg_d[timed_unlock_pkg::POS_WD_RESTART] = 1'b0; // [R4]
      end
    end
    if (extended_flag_reg_wr) begin
      extended_flag_reg_d = merge(extended_flag_reg_q, avs_writedata[7:0], extended_flag_reg_ok); // [R5]
    end
    // hardware sets win over a clear in the same cycle
    if (wdt_irq_set) begin
      watchdog_control_reg_d[timed_unlock_pkg::POS_WD_IRQ] = 1'b1;
    end
    if (por_set) begin
      watchdog_control_reg_d[timed_unlock_pkg::POS_POR_FLAG] = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      watchdog_control_reg_q <= timed_unlock_pkg::WATCHDOG_CONTROL_REG_RESET;
      extended_flag_reg_q  <= timed_unlock_pkg::EXTENDED_FLAG_REG_RESET;
    end else begin
      watchdog_control_reg_q <= watchdog_control_reg_d;
      extended_flag_reg_q  <= extended_flag_reg_d;
    end
  end

  // ----------------------------------------------------------------
  // read data, captured in the wait cycle
  // ----------------------------------------------------------------
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (avs_read && !ack_q) begin
      if (hit_watchdog_control_reg) begin
        rdata_d[7:0] = watchdog_control_reg_q;
      end else if (hit_extended_flag_reg) begin
        rdata_d[7:0] = extended_flag_reg_q;
      end else if (hit_status) begin
        rdata_d[timed_unlock_pkg::POS_ST_OPEN]  = window_open;
        rdata_d[timed_unlock_pkg::POS_ST_ARMED] = armed;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q   <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign avs_readdata         = rdata_q;
  assign watchdog_control_reg = watchdog_control_reg_q;
  assign extended_flag_reg    = extended_flag_reg_q;
  assign bandgap_select       = extended_flag_reg_q[timed_unlock_pkg::POS_BANDGAP];
  assign watchdog_enable_bit  = watchdog_control_reg_q[timed_unlock_pkg::POS_WD_ENABLE];
  assign watchdog_restart_bit = watchdog_control_reg_q[timed_unlock_pkg::POS_WD_RESTART];
  assign watchdog_irq_flag    = watchdog_control_reg_q[timed_unlock_pkg::POS_WD_IRQ];
  assign por_flag             = watchdog_control_reg_q[timed_unlock_pkg::POS_POR_FLAG];
  assign unlock_open          = window_open;

endmodule
`default_nettype wire

// ### timed_write_unlock_tb.sv
// self-checking testbench for the timed write unlock gate
`timescale 1ns/1ps
`default_nettype none
module timed_write_unlock_tb;
  localparam logic [11:0] A_KEY = 12'h31C;
  localparam logic [11:0] A_WD  = 12'h360;
  localparam logic [11:0] A_EX  = 12'h100;
  localparam logic [11:0] A_ST  = 12'h104;
  localparam logic [7:0]  WDM   = timed_unlock_pkg::WATCHDOG_CONTROL_REG_PROT_MASK;
  logic        mclk, resetn, avs_read, avs_write, wdt_irq_set, por_set;
  logic        avs_waitrequest, bandgap_select, watchdog_enable_bit, k;
  logic        watchdog_restart_bit, watchdog_irq_flag, por_flag, unlock_open;
  logic [11:0] avs_address;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rdata;
  logic [7:0]  watchdog_control_reg, extended_flag_reg, wd_m, d;
  int          err_count, comparisons, i;
  timed_write_unlock dut (.mclk(mclk), .resetn(resetn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .wdt_irq_set(wdt_irq_set), .por_set(por_set),
    .watchdog_control_reg(watchdog_control_reg),
    .extended_flag_reg(extended_flag_reg), .bandgap_select(bandgap_select),
    .watchdog_enable_bit(watchdog_enable_bit),
    .watchdog_restart_bit(watchdog_restart_bit),
    .watchdog_irq_flag(watchdog_irq_flag), .por_flag(por_flag),
    .unlock_open(unlock_open));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] e, got);
    comparisons++;
    if (got !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, got);
    end
  endtask
  task automatic bus(input logic wr, input logic [11:0] a, input logic [7:0] v);
    int n;
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h000000, v};
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (n >= 20) begin
      err_count++;
      $display("Error waitrequest expected 0 seen 1");
      end_of_test();
    end
    rdata = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    check("readdata", {24'h000000, e}, rdata);
  endtask
  task automatic unlock;
    bus(1'b1, A_KEY, timed_unlock_pkg::KEY_FIRST);
    bus(1'b1, A_KEY, timed_unlock_pkg::KEY_SECOND);
  endtask
  initial begin
    {resetn, avs_read, avs_write, wdt_irq_set, por_set} = 5'h00;
    avs_address = 12'h000;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'hF;
    {err_count, comparisons, wd_m} = 0;
    i = $urandom(26821);
    repeat (20) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    rd(A_WD, 8'h00);
    rd(A_EX, 8'h00);
    rd(A_KEY, 8'h00);
    rd(12'h200, 8'h00);
    $display("test reset done");
    for (i = 0; i < 24; i++) begin
      d = 8'($urandom());
      k = 1'($urandom());
      if (k) unlock();
      bus(1'b1, A_WD, d);
      wd_m = k ? d : (wd_m & WDM) | (d & ~WDM);
      wd_m[0] = 1'b0;
      rd(A_WD, wd_m);
      check("enable", wd_m[1], watchdog_enable_bit);
      check("watchdog_control_reg", wd_m, watchdog_control_reg);
    end
    $display("test random done");
    unlock();
    repeat (12) @(posedge mclk);
    bus(1'b1, A_EX, 8'h01);
    rd(A_EX, 8'h00);
    bus(1'b1, A_KEY, 8'hAA);
    bus(1'b1, A_KEY, 8'h56);
    bus(1'b1, A_KEY, 8'h55);
    rd(A_ST, 8'h00);
    bus(1'b1, A_EX, 8'h01);
    rd(A_EX, 8'h00);
    bus(1'b1, A_KEY, 8'hAA);
    unlock();
    rd(A_ST, 8'h01);
    bus(1'b1, A_EX, 8'h01);
    check("bandgap", 1'b1, bandgap_select);
    check("extended_flag_reg", 8'h01, extended_flag_reg);
    bus(1'b1, A_KEY, 8'hAA);
    bus(1'b1, A_EX, 8'h00);
    bus(1'b1, A_KEY, 8'h55);
    bus(1'b1, A_EX, 8'h00);
    rd(A_EX, 8'h01);
    $display("test sequence done");
    wdt_irq_set <= 1'b1;
    por_set <= 1'b1;
    @(posedge mclk);
    wdt_irq_set <= 1'b0;
    por_set <= 1'b0;
    @(posedge mclk);
    check("irq_flag", 1'b1, watchdog_irq_flag);
    check("por_flag", 1'b1, por_flag);
    wd_m = wd_m | 8'h48;
    bus(1'b1, A_WD, wd_m & 8'hB4);
    rd(A_WD, wd_m);
    unlock();
    bus(1'b1, A_WD, 8'h00);
    rd(A_WD, 8'h00);
    $display("test flags done");
    end_of_test();
  end
endmodule
bind timed_write_unlock unlock_checker chk (.mclk(mclk), .resetn(resetn),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .wdt_irq_set(wdt_irq_set),
  .por_set(por_set), .bandgap_select(bandgap_select),
  .watchdog_enable_bit(watchdog_enable_bit),
  .watchdog_restart_bit(watchdog_restart_bit),
  .watchdog_irq_flag(watchdog_irq_flag), .por_flag(por_flag),
  .unlock_open(unlock_open));
`default_nettype wire

// ### unlock_checker_assertions.sv
// port assertions for the timed write unlock gate
`timescale 1ns/1ps
`default_nettype none
module unlock_checker (
  // clock and reset
  input wire logic        mclk,
  input wire logic        resetn,
  // bus
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // flags and controls
  input wire logic        wdt_irq_set,
  input wire logic        por_set,
  input wire logic        bandgap_select,
  input wire logic        watchdog_enable_bit,
  input wire logic        watchdog_restart_bit,
  input wire logic        watchdog_irq_flag,
  input wire logic        por_flag,
  input wire logic        unlock_open
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  // ----------------------------------------------------------------
  // open window length
  // ----------------------------------------------------------------
  logic [7:0] open_q;
  logic [7:0] open_d;
  always_comb open_d = unlock_open ? open_q + 8'h01 : 8'h00;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) open_q <= 8'h00;
    else open_q <= open_d;
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_wait_once: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("more than one wait cycle");
  a_read_upper: assert property (avs_readdata[31:8] == 24'h000000)
    else $error("upper read data not zero");
  a_window_max: assert property (open_q <= 8'h0C)
    else $error("window open too long");
  a_enable_gate: assert property (!unlock_open |=>
    $stable(watchdog_enable_bit)) else $error("enable changed while locked");
  a_bandgap_gate: assert property (!unlock_open |=>
    $stable(bandgap_select)) else $error("bandgap changed while locked");
  a_irq_gate: assert property (!unlock_open && !wdt_irq_set |=>
    $stable(watchdog_irq_flag)) else $error("irq flag changed while locked");
  a_por_gate: assert property (!unlock_open && !por_set |=>
    $stable(por_flag)) else $error("por flag changed while locked");
  a_restart_pulse: assert property (watchdog_restart_bit |->
    $past(unlock_open) ##1 !watchdog_restart_bit)
    else $error("restart pulse wrong");
  c_open: cover property ($rose(unlock_open));
  c_restart: cover property (watchdog_restart_bit);
  c_bandgap: cover property ($rose(bandgap_select));
endmodule
`default_nettype wire

// ### unlock_sequencer.sv
// key sequence detector and unlock window timer
`timescale 1ns/1ps
`default_nettype none
module unlock_sequencer #(
  parameter int WINDOW_LEN = timed_unlock_pkg::WINDOW_CLOCKS,
  parameter int CNT_W      = 8
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             resetn,
  // write events
  input  wire logic             key_wr,
  input  wire logic [7:0]       key_data,
  input  wire logic             prot_wr,
  // state
  output logic                  armed,
  output logic                  window_open
);

  initial begin
    if (WINDOW_LEN < 1 || WINDOW_LEN > (1 << CNT_W))
      $error("unlock_sequencer: WINDOW_LEN does not fit CNT_W");
  end

  timed_unlock_pkg::seq_state_e state_q;
  timed_unlock_pkg::seq_state_e state_d;
  logic [CNT_W-1:0]             cnt_q;
  logic [CNT_W-1:0]             cnt_d;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    unique case (state_q)
      timed_unlock_pkg::SEQ_IDLE: begin
        if (key_wr && key_data == timed_unlock_pkg::KEY_FIRST) begin
          state_d = timed_unlock_pkg::SEQ_ARMED; // [R1]
        end
      end
      timed_unlock_pkg::SEQ_ARMED: begin
        if (key_wr) begin
          if (key_data == timed_unlock_pkg::KEY_SECOND) begin
            state_d = timed_unlock_pkg::SEQ_OPEN; // [R1] [R2]
            cnt_d   = CNT_W'(WINDOW_LEN - 1);
          end else if (key_data == timed_unlock_pkg::KEY_FIRST) begin
            state_d = timed_unlock_pkg::SEQ_ARMED; // [R6]
          end else begin
            state_d = timed_unlock_pkg::SEQ_IDLE; // [R6]
          end
        end else if (prot_wr) begin
          state_d = timed_unlock_pkg::SEQ_IDLE; // [R3]
        end
      end
      timed_unlock_pkg::SEQ_OPEN: begin
        if (key_wr && key_data == timed_unlock_pkg::KEY_FIRST) begin
          state_d = timed_unlock_pkg::SEQ_ARMED;
        end else if (prot_wr || key_wr || cnt_q == '0) begin
          // one protected write per window, then closed [R2]
          state_d = timed_unlock_pkg::SEQ_IDLE;
        end else begin
          cnt_d = cnt_q - CNT_W'(1); // [R2]
        end
      end
      default: begin
        state_d = timed_unlock_pkg::SEQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_q <= timed_unlock_pkg::SEQ_IDLE;
      cnt_q   <= '0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  assign armed       = (state_q == timed_unlock_pkg::SEQ_ARMED);
  assign window_open = (state_q == timed_unlock_pkg::SEQ_OPEN);

endmodule
`default_nettype wire
